//--- hdl/dmb_core.sv
// The APB interface to the registers and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
// Behaviour
// - post-increment pointer read, two clocks
// - pre-decrement pointer read, two clocks
// - offset read leaves pointer unchanged
// - absolute address read, two clocks
// - post-increment pointer write, two clocks
// - pre-decrement pointer write, two clocks
// - offset write leaves pointer unchanged
// - absolute address write, two clocks
// - push onto stack, two clocks
// - pop from stack, two clocks
// - set one io bit, two clocks
// - clear one io bit, two clocks
// - rotate left through carry, one clock
// - rotate right through carry, one clock
// - copy register bit into T flag
// - copy T flag into register bit
// - set and clear overflow flag only
// - set and clear signed flag only
// - set and clear half-carry flag only
// - sleep takes three clocks, enters low power
// - watchdog kick in one clock
// - branch on global interrupt flag
module dmb_core (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // data memory and stack
    output logic [15:0] dmem_addr,
    output logic dmem_re,
    output logic dmem_we,
    output logic [7:0] dmem_wdata,
    input wire logic [7:0] dmem_rdata,
    // io register space
    output logic [5:0] io_addr,
    output logic io_re,
    output logic io_we,
    output logic [7:0] io_wdata,
    input wire logic [7:0] io_rdata,
    // system
    output logic busy,
    output logic sleep_req,
    output logic wdt_kick,
    output logic branch_taken
);
    import dmb_pkg::*;

    default clocking dmb_cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    logic [31:0] prdata_ff, instr_ff;
    logic pready_ff, pslverr_ff;
    logic [15:0] addr_ff, x_ff, y_ff, z_ff, sp_ff;
    logic [7:0] flags_ff, dwdata_ff, iowdata_ff;
    logic [15:0] daddr_ff;
    logic dre_ff, dwe_ff, iore_ff, iowe_ff;
    logic [5:0] ioaddr_ff;
    logic busy_ff, first_ff, sleep_ff, sleep_en_ff, kick_ff, branch_ff;
    logic [1:0] cnt_ff;
    dmb_state_t state_ff;
    logic [7:0] rd_data, rf_wdata, rot;
    logic [4:0] rf_raddr, rf_waddr;
    logic rf_we;

    // decoded fields of the incoming and the latched word
    dmb_op_t w_op, i_op;
    dmb_mode_t w_mode;
    dmb_ptr_t w_ptr;
    logic [15:0] w_pval, w_addr;
    logic [2:0] i_bit;
    logic [7:0] i_mask;
    logic acc, wr_acc, is_gpr, legal, start, e1;

    function automatic logic [1:0] op_clocks(input dmb_op_t op);
        unique case (op)
            OP_RD_PTR, OP_WR_PTR, OP_RD_ABS, OP_WR_ABS, OP_PUSH, OP_POP,
            OP_IO_ON, OP_IO_OFF: op_clocks = CLK_TWO;
            OP_SLEEP: op_clocks = CLK_THREE;
            default: op_clocks = CLK_ONE;
        endcase
    endfunction

    function automatic logic [15:0] ptr_addr(input dmb_mode_t md,
            input logic [15:0] p, input logic [DISP_W-1:0] q);
        unique case (md)
            MD_PRE_DEC: ptr_addr = p - 16'h0001;
            MD_DISP: ptr_addr = p + {10'h000, q};
            default: ptr_addr = p;
        endcase
    endfunction

    function automatic logic [15:0] ptr_next(input dmb_mode_t md,
            input logic [15:0] p);
        unique case (md)
            MD_POST_INC: ptr_next = p + 16'h0001;
            MD_PRE_DEC: ptr_next = p - 16'h0001;
            default: ptr_next = p;
        endcase
    endfunction

    assign w_op = dmb_op_t'(pwdata[OP_LSB +: OP_W]);
    assign w_mode = dmb_mode_t'(pwdata[MODE_LSB +: 2]);
    assign w_ptr = dmb_ptr_t'(pwdata[PTR_LSB +: 2]);
    assign i_op = dmb_op_t'(instr_ff[OP_LSB +: OP_W]);
    assign i_bit = instr_ff[BIT_LSB +: 3];
    assign i_mask = 8'h01 << i_bit;
    assign w_pval = (w_ptr == PT_X) ? x_ff :
                    (w_ptr == PT_Y) ? y_ff : z_ff;
    assign w_addr = ptr_addr(w_mode, w_pval, pwdata[DISP_LSB +: DISP_W]);

    assign acc = psel && penable && pready_ff;
    assign wr_acc = acc && pwrite;
    assign is_gpr = (paddr & GPR_WIN_MASK) == OFS_GPR_BASE;
    // offset addressing exists only for the middle and last pointer
    assign legal = (w_op <= OP_BR_IFLAG) && !((w_op == OP_RD_PTR ||
        w_op == OP_WR_PTR) && (w_ptr == PT_NONE ||
        (w_mode == MD_DISP && w_ptr == PT_X)));
    assign start = wr_acc && paddr == OFS_INSTR && !busy_ff && legal;
    assign e1 = state_ff == S_EXEC && first_ff;
    assign rot = (i_op == OP_ROL) ? {rd_data[6:0], flags_ff[FL_C]} :
                 {flags_ff[FL_C], rd_data[7:1]};

    // register file ports
    always_comb begin
        rf_raddr = start ? pwdata[REG_LSB +: 5] : paddr[6:2];
        rf_we = 1'b0;
        rf_waddr = instr_ff[REG_LSB +: 5];
        rf_wdata = dmem_rdata;
        if (e1) begin
            unique case (i_op)
                OP_RD_PTR, OP_RD_ABS, OP_POP: begin
                    rf_we = 1'b1;
                end
                OP_ROL, OP_ROR: begin
                    rf_we = 1'b1;
                    rf_wdata = rot;
                end
                OP_BIT_IN: begin
                    rf_we = 1'b1;
                    rf_wdata = flags_ff[FL_T] ? (rd_data | i_mask) :
                               (rd_data & ~i_mask);
                end
                default: rf_we = 1'b0;
            endcase
        end else if (wr_acc && is_gpr && !busy_ff) begin
            rf_we = 1'b1;
            rf_waddr = paddr[6:2];
            rf_wdata = pwdata[7:0];
        end
    end

    dmb_regfile #(.DEPTH(32), .AW(5), .DW(8)) u_rf (
        .pclk(pclk),
        .we(rf_we),
        .waddr(rf_waddr),
        .wdata(rf_wdata),
        .raddr(rf_raddr),
        .rdata(rd_data)
    );

    // apb: one wait state, error on unmapped or refused access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= 32'h0000_0000;
        end else begin
            pready_ff <= psel && penable && !pready_ff;
            if (psel && penable && !pready_ff) begin
                pslverr_ff <= 1'b0;
                prdata_ff <= 32'h0000_0000;
                if (is_gpr) begin
                    pslverr_ff <= busy_ff;
                    prdata_ff <= {24'h000000, rd_data};
                end else begin
                    unique case (paddr)
                        OFS_INSTR: begin
                            prdata_ff <= instr_ff;
                            pslverr_ff <= pwrite && (busy_ff || !legal);
                        end
                        OFS_ADDR: prdata_ff <= {16'h0000, addr_ff};
                        OFS_FLAGS: prdata_ff <= {24'h000000, flags_ff};
                        OFS_PTR_X: prdata_ff <= {16'h0000, x_ff};
                        OFS_PTR_Y: prdata_ff <= {16'h0000, y_ff};
                        OFS_PTR_Z: prdata_ff <= {16'h0000, z_ff};
                        OFS_SP: prdata_ff <= {16'h0000, sp_ff};
                        OFS_STATUS: prdata_ff <= {29'h0, branch_ff,
                                                  sleep_ff, busy_ff};
                        OFS_SLEEP_CTRL: prdata_ff <= {31'h0, sleep_en_ff};
                        default: pslverr_ff <= 1'b1;
                    endcase
                    if (pwrite && paddr != OFS_INSTR &&
                            paddr != OFS_STATUS && busy_ff) begin
                        pslverr_ff <= 1'b1;
                    end
                end
            end
        end
    end

    // sequencer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff <= S_IDLE;
            busy_ff <= 1'b0;
            first_ff <= 1'b0;
            cnt_ff <= CLK_ONE;
            instr_ff <= 32'h0000_0000;
        end else begin
            first_ff <= start;
            if (start) begin
                state_ff <= S_EXEC;
                busy_ff <= 1'b1;
                cnt_ff <= op_clocks(w_op);
                instr_ff <= pwdata;
            end else if (state_ff == S_EXEC) begin
                if (cnt_ff == CLK_ONE) begin
                    state_ff <= S_IDLE;
                    busy_ff <= 1'b0;
                end else begin
                    cnt_ff <= cnt_ff - 2'h1;
                end
            end
        end
    end

    // pointers, stack pointer and absolute address
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            x_ff <= PTR_RST;
            y_ff <= PTR_RST;
            z_ff <= PTR_RST;
            sp_ff <= SP_RST;
            addr_ff <= PTR_RST;
        end else if (start) begin
            if (w_op == OP_RD_PTR || w_op == OP_WR_PTR) begin
                unique case (w_ptr)
                    PT_X: x_ff <= ptr_next(w_mode, x_ff);
                    PT_Y: y_ff <= ptr_next(w_mode, y_ff);
                    PT_Z: z_ff <= ptr_next(w_mode, z_ff);
                    default: x_ff <= x_ff;
                endcase
            end
            if (w_op == OP_PUSH) begin
                sp_ff <= sp_ff - 16'h0001;
            end else if (w_op == OP_POP) begin
                sp_ff <= sp_ff + 16'h0001;
            end
        end else if (wr_acc && !busy_ff) begin
            unique case (paddr)
                OFS_PTR_X: x_ff <= pwdata[15:0];
                OFS_PTR_Y: y_ff <= pwdata[15:0];
                OFS_PTR_Z: z_ff <= pwdata[15:0];
                OFS_SP: sp_ff <= pwdata[15:0];
                OFS_ADDR: addr_ff <= pwdata[15:0];
                default: sp_ff <= sp_ff;
            endcase
        end
    end

    // data memory and stack requests
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            daddr_ff <= PTR_RST;
            dre_ff <= 1'b0;
            dwe_ff <= 1'b0;
            dwdata_ff <= 8'h00;
        end else begin
            dre_ff <= 1'b0;
            dwe_ff <= 1'b0;
            if (start) begin
                unique case (w_op)
                    OP_RD_PTR, OP_WR_PTR: begin
                        daddr_ff <= w_addr;
                    end
                    OP_RD_ABS, OP_WR_ABS: begin
                        daddr_ff <= addr_ff;
                    end
                    OP_PUSH: daddr_ff <= sp_ff;
                    OP_POP: daddr_ff <= sp_ff + 16'h0001;
                    default: daddr_ff <= daddr_ff;
                endcase
                dre_ff <= w_op == OP_RD_PTR || w_op == OP_RD_ABS ||
                          w_op == OP_POP;
            end
            if (e1 && (i_op == OP_WR_PTR || i_op == OP_WR_ABS ||
                    i_op == OP_PUSH)) begin
                dwe_ff <= 1'b1;
                dwdata_ff <= rd_data;
            end
        end
    end

    // io read-modify-write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ioaddr_ff <= 6'h00;
            iore_ff <= 1'b0;
            iowe_ff <= 1'b0;
            iowdata_ff <= 8'h00;
        end else begin
            iore_ff <= 1'b0;
            iowe_ff <= 1'b0;
            if (start && (w_op == OP_IO_ON || w_op == OP_IO_OFF)) begin
                ioaddr_ff <= addr_ff[5:0];
                iore_ff <= 1'b1;
            end
            if (e1 && i_op == OP_IO_ON) begin
                iowe_ff <= 1'b1;
                iowdata_ff <= io_rdata | i_mask;
            end else if (e1 && i_op == OP_IO_OFF) begin
                iowe_ff <= 1'b1;
                iowdata_ff <= io_rdata & ~i_mask;
            end
        end
    end

    // flag_register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags_ff <= FLAGS_RST;
        end else if (e1) begin
            unique case (i_op)
                OP_ROL, OP_ROR: begin
                    flags_ff[FL_C] <= (i_op == OP_ROL) ? rd_data[7] :
                                      rd_data[0];
                    flags_ff[FL_Z] <= rot == 8'h00;
                    flags_ff[FL_N] <= rot[7];
                    flags_ff[FL_V] <= rot[7] ^ ((i_op == OP_ROL) ?
                                      rd_data[7] : rd_data[0]);
                end
                OP_BIT_OUT: flags_ff[FL_T] <= rd_data[i_bit];
                OP_FLAG_ON: flags_ff[i_bit] <= 1'b1;
                OP_FLAG_OFF: begin
                    flags_ff[i_bit] <= 1'b0;
                end
                default: flags_ff <= flags_ff;
            endcase
        end else if (wr_acc && !busy_ff && paddr == OFS_FLAGS) begin
            flags_ff <= pwdata[7:0];
        end
    end

    // sleep, watchdog kick, branch result
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sleep_en_ff <= 1'b0;
            sleep_ff <= 1'b0;
            kick_ff <= 1'b0;
            branch_ff <= 1'b0;
        end else begin
            kick_ff <= start && w_op == OP_KICK;
            if (wr_acc && !busy_ff && paddr == OFS_SLEEP_CTRL) begin
                sleep_en_ff <= pwdata[0];
            end
            if (start) begin
                sleep_ff <= w_op == OP_SLEEP && sleep_en_ff;
                branch_ff <= 1'b0;
            end
            if (e1 && i_op == OP_BR_IFLAG) begin
                branch_ff <= flags_ff[FL_I] == instr_ff[WANT_POS];
            end
        end
    end

    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign dmem_addr = daddr_ff;
    assign dmem_re = dre_ff;
    assign dmem_we = dwe_ff;
    assign dmem_wdata = dwdata_ff;
    assign io_addr = ioaddr_ff;
    assign io_re = iore_ff;
    assign io_we = iowe_ff;
    assign io_wdata = iowdata_ff;
    assign busy = busy_ff;
    assign sleep_req = sleep_ff;
    assign wdt_kick = kick_ff;
    assign branch_taken = branch_ff;

    // checks
    a_post_inc: assert property (
        start && w_op == OP_RD_PTR && w_mode == MD_POST_INC &&
        w_ptr == PT_Z |=> z_ff == $past(z_ff) + 16'h0001 &&
        daddr_ff == $past(z_ff) && dre_ff)
        else $error("post-increment read wrong");
    a_pre_dec: assert property (
        start && w_op == OP_WR_PTR && w_mode == MD_PRE_DEC &&
        w_ptr == PT_Y |=> daddr_ff == $past(y_ff) - 16'h0001 ##1 dwe_ff)
        else $error("pre-decrement write wrong");
    a_disp_keep: assert property (
        start && w_mode == MD_DISP && w_ptr == PT_Y |=> $stable(y_ff))
        else $error("offset access moved pointer");
    a_load_data: assert property (
        e1 && i_op == OP_RD_ABS |-> rf_we && dre_ff &&
        daddr_ff == addr_ff && rf_wdata == dmem_rdata)
        else $error("absolute read data lost");
    a_store_data: assert property (
        e1 && i_op == OP_WR_ABS |=> dwe_ff && dwdata_ff == $past(rd_data)
        ##1 !dwe_ff)
        else $error("absolute write wrong");
    a_io_set: assert property (
        start && w_op == OP_IO_ON |=> iore_ff ##1
        iowe_ff && iowdata_ff == ($past(io_rdata) | $past(i_mask)))
        else $error("io bit set wrong");
    a_rotate_c: assert property (
        e1 && i_op == OP_ROL |=> flags_ff[FL_C] == $past(rd_data[7]) &&
        flags_ff[FL_T] == $past(flags_ff[FL_T]))
        else $error("rotate carry wrong");
    a_flag_only: assert property (
        e1 && i_op == OP_FLAG_ON |=> (flags_ff & ~$past(i_mask)) ==
        ($past(flags_ff) & ~$past(i_mask)) && (flags_ff & $past(i_mask)) != 0)
        else $error("flag set touched others");
    a_sleep_len: assert property (
        start && w_op == OP_SLEEP |=> busy_ff [*3] ##1 !busy_ff)
        else $error("sleep length wrong");
    a_mem_len: assert property (
        start && w_op == OP_PUSH |=> busy_ff [*2] ##1 !busy_ff)
        else $error("two-clock hold wrong");
    a_kick_pulse: assert property (
        start && w_op == OP_KICK |=> kick_ff && busy_ff ##1
        !kick_ff && !busy_ff)
        else $error("watchdog kick wrong");
    a_branch_i: assert property (
        e1 && i_op == OP_BR_IFLAG |=> branch_ff ==
        ($past(flags_ff[FL_I]) == $past(instr_ff[WANT_POS])) &&
        $stable(flags_ff))
        else $error("interrupt-flag branch wrong");
    c_pop: cover property (@(posedge pclk) disable iff (!presetn)
        start && w_op == OP_POP);
    c_io_off: cover property (@(posedge pclk) disable iff (!presetn)
        e1 && i_op == OP_IO_OFF);
    c_ror: cover property (@(posedge pclk) disable iff (!presetn)
        e1 && i_op == OP_ROR);
    c_refused: cover property (@(posedge pclk) disable iff (!presetn)
        acc && pwrite && busy_ff && paddr == OFS_INSTR);
endmodule

//--- hdl/dmb_regfile.sv
`timescale 1ns/1ps
module dmb_regfile #(
    parameter int DEPTH = 32,
    parameter int AW = 5,
    parameter int DW = 8
) (
    // clock
    input wire logic pclk,
    // write port
    input wire logic we,
    input wire logic [AW-1:0] waddr,
    input wire logic [DW-1:0] wdata,
    // read port
    input wire logic [AW-1:0] raddr,
    output logic [DW-1:0] rdata
);
    logic [DW-1:0] mem [DEPTH];

    always_ff @(posedge pclk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    // registered read, write-first
    always_ff @(posedge pclk) begin
        if (we && waddr == raddr) begin
            rdata <= wdata;
        end else begin
            rdata <= mem[raddr];
        end
    end
endmodule

//--- include/dmb_pkg.sv
package dmb_pkg;
    // register byte offsets
    localparam logic [11:0] OFS_INSTR = 12'h000;
    localparam logic [11:0] OFS_ADDR = 12'h004;
    localparam logic [11:0] OFS_FLAGS = 12'h008;
    localparam logic [11:0] OFS_PTR_X = 12'h00c;
    localparam logic [11:0] OFS_PTR_Y = 12'h010;
    localparam logic [11:0] OFS_PTR_Z = 12'h014;
    localparam logic [11:0] OFS_SP = 12'h018;
    localparam logic [11:0] OFS_STATUS = 12'h01c;
    localparam logic [11:0] OFS_SLEEP_CTRL = 12'h020;
    localparam logic [11:0] OFS_GPR_BASE = 12'h100;
    localparam logic [11:0] GPR_WIN_MASK = 12'hf80;
    // instruction word fields
    localparam int OP_LSB = 0;
    localparam int OP_W = 5;
    localparam int MODE_LSB = 5;
    localparam int PTR_LSB = 8;
    localparam int REG_LSB = 10;
    localparam int BIT_LSB = 16;
    localparam int DISP_LSB = 24;
    localparam int DISP_W = 6;
    localparam int WANT_POS = 31;
    // flag_register bit positions
    localparam int FL_C = 0;
    localparam int FL_Z = 1;
    localparam int FL_N = 2;
    localparam int FL_V = 3;
    localparam int FL_S = 4;
    localparam int FL_H = 5;
    localparam int FL_T = 6;
    localparam int FL_I = 7;
    // status bit positions
    localparam int ST_BUSY = 0;
    localparam int ST_SLEEP = 1;
    localparam int ST_BRANCH = 2;
    // reset values
    localparam logic [7:0] FLAGS_RST = 8'h00;
    localparam logic [15:0] PTR_RST = 16'h0000;
    localparam logic [15:0] SP_RST = 16'h00df;
    // instruction clock counts minus one
    localparam logic [1:0] CLK_ONE = 2'h0;
    localparam logic [1:0] CLK_TWO = 2'h1;
    localparam logic [1:0] CLK_THREE = 2'h2;

    typedef enum logic [4:0] {
        OP_NOP, OP_RD_PTR, OP_WR_PTR, OP_RD_ABS, OP_WR_ABS, OP_PUSH,
        OP_POP, OP_IO_ON, OP_IO_OFF, OP_ROL, OP_ROR, OP_BIT_OUT,
        OP_BIT_IN, OP_FLAG_ON, OP_FLAG_OFF, OP_SLEEP, OP_KICK, OP_BR_IFLAG
    } dmb_op_t;

    typedef enum logic [1:0] {
        MD_PLAIN, MD_POST_INC, MD_PRE_DEC, MD_DISP
    } dmb_mode_t;

    typedef enum logic [1:0] {PT_X, PT_Y, PT_Z, PT_NONE} dmb_ptr_t;

    typedef enum logic {S_IDLE, S_EXEC} dmb_state_t;
endpackage

//--- tb/dmb_mem_model.sv
`timescale 1ns/1ps
module dmb_mem_model (
    // clock
    input wire logic pclk,
    // data memory
    input wire logic [15:0] dmem_addr,
    input wire logic dmem_re,
    input wire logic dmem_we,
    input wire logic [7:0] dmem_wdata,
    output logic [7:0] dmem_rdata,
    // io space
    input wire logic [5:0] io_addr,
    input wire logic io_re,
    input wire logic io_we,
    input wire logic [7:0] io_wdata,
    output logic [7:0] io_rdata
);
    logic [7:0] mem [0:65535];
    logic [7:0] io [0:63];
    logic [7:0] last_d = 8'h00;
    logic [7:0] last_i = 8'h00;
    initial begin
        for (int i = 0; i < 64; i++) io[i] = 8'ha5;
    end
    // idle read lines show the inverse of the last value
    assign dmem_rdata = dmem_re ? mem[dmem_addr] : ~last_d;
    assign io_rdata = io_re ? io[io_addr] : ~last_i;
    always @(posedge pclk) begin
        if (dmem_re) last_d <= mem[dmem_addr];
        if (dmem_we) mem[dmem_addr] <= dmem_wdata;
        if (io_re) last_i <= io[io_addr];
        if (io_we) io[io_addr] <= io_wdata;
    end
endmodule

//--- tb/tb.sv
`timescale 1ns/1ps
module tb;
    import dmb_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, kk;
    logic [11:0] paddr, a;
    logic [31:0] pwdata, prdata, b;
    logic [15:0] dmem_addr;
    logic dmem_re, dmem_we, io_re, io_we, busy, sleep_req, wdt_kick;
    logic branch_taken;
    logic [7:0] dmem_wdata, dmem_rdata, io_wdata, io_rdata, v;
    logic [5:0] io_addr;
    logic [33:0] q[$];
    logic [33:0] nt;
    int error_cnt, checks_done;
    dmb_core dmb_core_i (.*);
    dmb_mem_model dmb_mem_model_i (.*);
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    task automatic test_done;
        $display("errors %0d checks %0d", error_cnt, checks_done);
        if (error_cnt == 0 && checks_done > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, g);
        checks_done++;
        if (g !== e) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    function automatic logic [31:0] ins(input int op, md, pt, rg, bt, ds);
        return 32'(op | md << 5 | pt << 8 | rg << 10 | bt << 16 | ds << 24);
    endfunction
    function automatic logic [11:0] gpr(input int n);
        return OFS_GPR_BASE + 12'(4 * n);
    endfunction
    // one apb transfer; d is write data or expected read data
    task automatic apb(input logic w, input logic [11:0] ad,
            input logic [31:0] d, input logic e, input logic bb);
        int n;
        q.push_back({~w, e, d});
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= ad;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (!pready && n < 8);
        if (pready !== 1'b1) begin
            error_cnt++;
            test_done();
        end
        if (!bb) begin
            psel <= 1'b0;
            penable <= 1'b0;
            @(posedge pclk);
        end
    endtask
    task automatic ex(input logic [31:0] w, input int nc);
        int n;
        apb(1, OFS_INSTR, w, 0, 1);
        psel <= 1'b0;
        penable <= 1'b0;
        n = 0;
        kk = 1'b0;
        for (int i = 0; i < 10; i++) begin
            @(posedge pclk);
            if (wdt_kick === 1'b1) kk = 1'b1;
            if (busy !== 1'b1) break;
            n++;
        end
        chk("busy cycles", nc, n);
    endtask
    always @(posedge pclk) begin
        if (psel && penable && pready) begin
            nt = q.pop_front();
            chk("pslverr", {31'h0, nt[32]}, {31'h0, pslverr});
            if (nt[33]) chk("prdata", nt[31:0], prdata);
        end
    end
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} <= '0;
        error_cnt = 0;
        checks_done = 0;
        void'($urandom(32'he219));
        v = 8'($urandom);
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(0, OFS_SP, 32'hdf, 0, 0);
        apb(1, gpr(3), {24'h0, v}, 0, 0);
        for (int p = 0; p < 3; p++) begin
            a = OFS_PTR_X + 12'(4 * p);
            b = 32'h40 + 32'(16 * p);
            apb(1, a, b, 0, 0);
            ex(ins(2, 1, p, 3, 0, 0), 2);
            ex(ins(1, 2, p, 4, 0, 0), 2);
            ex(ins(1, 1, p, 5, 0, 0), 2);
            apb(0, a, b + 1, 0, 0);
            ex(ins(2, 2, p, 5, 0, 0), 2);
            apb(0, a, b, 0, 0);
            apb(0, gpr(4), {24'h0, v}, 0, 0);
            apb(0, gpr(5), {24'h0, v}, 0, 0);
            if (p > 0) begin
                ex(ins(2, 3, p, 3, 0, 63), 2);
                ex(ins(1, 3, p, 6, 0, 63), 2);
                apb(0, gpr(6), {24'h0, v}, 0, 0);
                apb(0, a, b, 0, 0);
            end
        end
        ex(ins(1, 0, 0, 11, 0, 0), 2);
        apb(0, gpr(11), {24'h0, v}, 0, 0);
        apb(1, OFS_INSTR, ins(1, 3, 0, 0, 0, 0), 1, 0);
        apb(1, OFS_INSTR, ins(2, 1, 3, 0, 0, 0), 1, 0);
        apb(1, OFS_INSTR, 32'h12, 1, 0);
        apb(0, OFS_STATUS, 32'h0, 0, 0);
        apb(0, OFS_PTR_X, 32'h40, 0, 0);
        apb(1, OFS_ADDR, 32'h123, 0, 0);
        ex(ins(4, 0, 0, 3, 0, 0), 2);
        ex(ins(3, 0, 0, 7, 0, 0), 2);
        apb(0, gpr(7), {24'h0, v}, 0, 0);
        ex(ins(5, 0, 0, 3, 0, 0), 2);
        apb(0, OFS_SP, 32'hde, 0, 0);
        ex(ins(6, 0, 0, 8, 0, 0), 2);
        apb(0, gpr(8), {24'h0, v}, 0, 0);
        apb(0, OFS_SP, 32'hdf, 0, 0);
        apb(0, OFS_FLAGS, 32'h0, 0, 0);
        apb(1, OFS_ADDR, 32'h5, 0, 0);
        ex(ins(7, 0, 0, 0, 1, 0), 2);
        chk("io on", 32'ha7, dmb_mem_model_i.io[5]);
        ex(ins(8, 0, 0, 0, 0, 0), 2);
        chk("io off", 32'ha6, dmb_mem_model_i.io[5]);
        apb(1, gpr(9), 32'h80, 0, 0);
        apb(1, OFS_FLAGS, 32'h1, 0, 0);
        ex(ins(9, 0, 0, 9, 0, 0), 1);
        apb(0, gpr(9), 32'h1, 0, 0);
        apb(0, OFS_FLAGS, 32'h9, 0, 0);
        ex(ins(10, 0, 0, 9, 0, 0), 1);
        apb(0, gpr(9), 32'h80, 0, 0);
        apb(0, OFS_FLAGS, 32'h5, 0, 0);
        ex(ins(11, 0, 0, 9, 7, 0), 1);
        apb(0, OFS_FLAGS, 32'h45, 0, 0);
        apb(1, gpr(10), 32'h0, 0, 0);
        ex(ins(12, 0, 0, 10, 3, 0), 1);
        apb(0, gpr(10), 32'h8, 0, 0);
        apb(1, OFS_FLAGS, 32'h0, 0, 0);
        for (int f = 3; f < 6; f++) begin
            ex(ins(13, 0, 0, 0, f, 0), 1);
            apb(0, OFS_FLAGS, 32'(1 << f), 0, 0);
            ex(ins(14, 0, 0, 0, f, 0), 1);
            apb(0, OFS_FLAGS, 32'h0, 0, 0);
        end
        apb(1, OFS_FLAGS, 32'h80, 0, 0);
        ex(ins(17, 0, 0, 0, 0, 0) | 32'h80000000, 1);
        chk("branch", 32'h1, {31'h0, branch_taken});
        ex(ins(17, 0, 0, 0, 0, 0), 1);
        chk("branch", 32'h0, {31'h0, branch_taken});
        ex(ins(16, 0, 0, 0, 0, 0), 1);
        chk("kick", 32'h1, {31'h0, kk});
        apb(1, OFS_SLEEP_CTRL, 32'h1, 0, 0);
        ex(ins(15, 0, 0, 0, 0, 0), 3);
        chk("sleep", 32'h1, {31'h0, sleep_req});
        apb(0, OFS_STATUS, 32'h2, 0, 0);
        apb(1, OFS_INSTR, ins(15, 0, 0, 0, 0, 0), 0, 1);
        apb(1, OFS_INSTR, 32'h0, 1, 0);
        apb(1, OFS_INSTR, ins(15, 0, 0, 0, 0, 0), 0, 1);
        apb(1, OFS_FLAGS, 32'hff, 1, 0);
        apb(0, OFS_FLAGS, 32'h80, 0, 0);
        apb(0, 12'h024, 32'h0, 1, 0);
        test_done();
    end
endmodule
